// File: hw/lutac_defines.svh
// Offsets, field positions and reset values of the lookup table access regs.
// Assumes byte addressing with the lowest address of a word holding 31:24.
`ifndef LUTAC_DEFINES_SVH
`define LUTAC_DEFINES_SVH

`define LUTAC_KEY_HIGH_OFS 16'h0410
`define LUTAC_KEY_LOW_OFS 16'h0414
`define LUTAC_ALU_CTRL_OFS 16'h0418
`define LUTAC_SM_CTRL_OFS 16'h041c
`define LUTAC_ENTRY_BASE_OFS 16'h0420
`define LUTAC_ENTRY_LAST_BYTE 16'h042f

`define LUTAC_KEY_HIGH_WMASK 32'h807f_ffff
`define LUTAC_KEY_LOW_WMASK 32'hffff_ffff
`define LUTAC_ALU_CTRL_WMASK 32'h0000_001f
`define LUTAC_SM_CTRL_WMASK 32'h003f_007f

`define LUTAC_KEY_HIGH_RST 32'h0000_0000
`define LUTAC_KEY_LOW_RST 32'h0000_0000
`define LUTAC_ALU_CTRL_RST 32'h0000_0000
`define LUTAC_SM_CTRL_RST 32'h0000_0000
`define LUTAC_ENTRY_RST 32'h0000_0000
`define LUTAC_COUNT_RST 14'h0000

`define LUTAC_GROUP_MSB 22
`define LUTAC_GROUP_LSB 16
`define LUTAC_MACH_MSB 15
`define LUTAC_MACH_LSB 0
`define LUTAC_DIRECT_IDX_MSB 11
`define LUTAC_COUNT_MSB 29
`define LUTAC_COUNT_LSB 16
`define LUTAC_GO_BIT 7
`define LUTAC_VALID_BIT 6
`define LUTAC_VEOS_BIT 5
`define LUTAC_DIRECT_BIT 2
`define LUTAC_ACT_MSB 1
`define LUTAC_ACT_LSB 0
`define LUTAC_TIDX_MSB 21
`define LUTAC_TIDX_LSB 16
`define LUTAC_SIDX_MSB 19
`define LUTAC_TSEL_BIT 1
`define LUTAC_TRD_BIT 0

`endif

// File: hw/lutac_pkg.sv
// Types shared by the lookup table access control block.
// Assumes the constants header is included by each user.
package lutac_pkg;

  typedef enum logic [1:0] {
    LUTAC_OP_NOP = 2'h0,
    LUTAC_OP_WRITE = 2'h1,
    LUTAC_OP_READ = 2'h2,
    LUTAC_OP_SEARCH = 2'h3
  } lutac_op_t;

  typedef enum logic [1:0] {
    LUTAC_TBL_ALU = 2'h0,
    LUTAC_TBL_STATIC = 2'h1,
    LUTAC_TBL_MCAST = 2'h2
  } lutac_tbl_t;

  typedef enum logic [1:0] {
    LUTAC_ST_IDLE = 2'h0,
    LUTAC_ST_ACCESS = 2'h1,
    LUTAC_ST_SEARCH = 2'h3
  } lutac_state_t;

  typedef struct packed {
    lutac_tbl_t tsel;
    lutac_op_t op;
    logic direct;
    logic [11:0] index;
    logic [6:0] filter_group_id;
    logic [47:0] mac;
  } lutac_cmd_t;

  typedef logic [3:0][31:0] lutac_entry_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lutac_host_req_t;

  typedef struct packed {
    logic rvalid;
    logic [7:0] rdata;
  } lutac_host_rsp_t;

endpackage

// File: hw/lutac_flag.sv
// Sticky flag that hardware sets and a reader clears.
// Assumes set and clear are single-cycle pulses on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module lutac_flag (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Control
  input wire logic set_i,
  input wire logic clr_i,
  output var logic q_o
);
  // An event landing with the clear is kept
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end
endmodule // lutac_flag
`default_nettype wire

// File: hw/lutac_cmd_build.sv
// Forms the table command from the key and control registers.
// Assumes the registers hold still while a table access runs.
`timescale 1ns/1ps
`default_nettype none
`include "lutac_defines.svh"
module lutac_cmd_build
  import lutac_pkg::*;
(
  // Register contents
  input wire logic [31:0] key_high_i,
  input wire logic [31:0] key_low_i,
  input wire logic [31:0] alu_ctrl_i,
  input wire logic [31:0] sm_ctrl_i,
  input wire logic pick_sm_i,
  // Command
  output var lutac_cmd_t cmd_o
);
  wire logic mcast_sel = sm_ctrl_i[`LUTAC_TSEL_BIT]; // R14
  wire lutac_tbl_t sm_tbl = mcast_sel ? LUTAC_TBL_MCAST : LUTAC_TBL_STATIC;
  wire lutac_op_t sm_op = sm_ctrl_i[`LUTAC_TRD_BIT] ? LUTAC_OP_READ
                                                     : LUTAC_OP_WRITE; // R15
  wire logic [11:0] mcast_idx =
    {6'h00, sm_ctrl_i[`LUTAC_TIDX_MSB:`LUTAC_TIDX_LSB]}; // R11
  wire logic [11:0] static_idx =
    {8'h00, sm_ctrl_i[`LUTAC_SIDX_MSB:`LUTAC_TIDX_LSB]}; // R12
  wire logic [11:0] sm_idx = mcast_sel ? mcast_idx : static_idx;
  wire logic alu_direct = alu_ctrl_i[`LUTAC_DIRECT_BIT]; // R9
  wire lutac_op_t alu_op =
    lutac_op_t'(alu_ctrl_i[`LUTAC_ACT_MSB:`LUTAC_ACT_LSB]); // R10
  wire logic [11:0] alu_idx =
    key_low_i[`LUTAC_DIRECT_IDX_MSB:0]; // R4

  always_comb begin
    cmd_o.filter_group_id =
      key_high_i[`LUTAC_GROUP_MSB:`LUTAC_GROUP_LSB]; // R1
    cmd_o.mac = {key_high_i[`LUTAC_MACH_MSB:`LUTAC_MACH_LSB],
                 key_low_i}; // R2 R3
    if (pick_sm_i) begin
      cmd_o.tsel = sm_tbl;
      cmd_o.op = sm_op;
      cmd_o.direct = 1'b1;
      cmd_o.index = sm_idx;
    end else begin
      cmd_o.tsel = LUTAC_TBL_ALU;
      cmd_o.op = alu_op;
      cmd_o.direct = alu_direct;
      cmd_o.index = alu_direct ? alu_idx : 12'h000;
    end
  end
endmodule // lutac_cmd_build
`default_nettype wire

// File: hw/lutac_main.sv
// Register bank for lookup, static and reserved multicast table access.
// Assumes a byte-wide host register port and a table engine behind it
// that answers each request with an ack or, for a search, entry strobes.
`timescale 1ns/1ps
`default_nettype none
`include "lutac_defines.svh"

// Operation
// R1: filter group id 22:16 feeds hash key
// R2: key high 15:0 gives MAC 47:32
// R3: key low gives MAC 31:0
// R4: direct mode indexes with key low 11:0
// R5: valid entry count shown after search
// R6: lookup go bit self-clears when done
// R7: entry ready set, cleared reading 0x042F
// R8: bit 5 is ready or search ended
// R9: bit 2 picks direct or hashed index
// R10: action 00 nop 01 write 10 read 11 search
// R11: multicast table uses index bits 21:16
// R12: static table uses index bits 19:16
// R13: static/multicast go bit self-clears when done
// R14: bit 1 picks multicast or static table
// R15: bit 0 picks read or write
// R16: static uses four entry words, multicast second
// R17: lookup data through entry words, key from index
// R18: fourth entry word at 0x042C to 0x042F
// R19: host leaves busy table registers alone
// R20: after last byte read, fetch next entry
module lutac_main
  import lutac_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Host register port
  input wire lutac_host_req_t host_req_i,
  output var lutac_host_rsp_t host_rsp_o,
  // Table request
  output var logic tbl_req_o,
  output var lutac_cmd_t tbl_cmd_o,
  output var lutac_entry_t tbl_wdata_o,
  // Table answer
  input wire logic tbl_ack_i,
  input wire lutac_entry_t tbl_rdata_i,
  // Search stream
  input wire logic srch_entry_i,
  input wire logic srch_end_i,
  input wire logic [13:0] srch_count_i,
  output var logic srch_next_o
);

  // Lane 0 is bits 31:24; the mask keeps read-only bits untouched
  function automatic logic [31:0] merge_byte(input logic [31:0] old,
                                             input logic [1:0] lane,
                                             input logic [7:0] data,
                                             input logic [31:0] wmask);
    logic [31:0] lane_mask;
    logic [31:0] shifted;
    lane_mask = 32'hff00_0000 >> {lane, 3'h0};
    shifted = {data, 24'h00_0000} >> {lane, 3'h0};
    merge_byte = (old & ~(lane_mask & wmask)) | (shifted & lane_mask & wmask);
  endfunction

  // Decode of a word address; the two low bits only pick the lane
  function automatic logic hits_word(input logic [15:0] addr,
                                     input logic [15:0] ofs);
    hits_word = addr[15:2] == ofs[15:2];
  endfunction

  // Big-endian byte pick for the read answer
  function automatic logic [7:0] pick_byte(input logic [31:0] word,
                                           input logic [1:0] lane);
    logic [31:0] shifted;
    shifted = word << {lane, 3'h0};
    pick_byte = shifted[31:24];
  endfunction

  lutac_state_t state;
  lutac_state_t next_state;
  logic [31:0] key_high;
  logic [31:0] key_low;
  logic [31:0] alu_ctrl;
  logic [31:0] sm_ctrl;
  logic alu_go;
  logic sm_go;
  logic [13:0] valid_count;
  lutac_entry_t entry;
  lutac_cmd_t built_cmd;
  logic entry_ready;
  logic search_ended;

  // Host decode
  wire logic [1:0] lane = host_req_i.addr[1:0];
  wire logic [15:0] word_addr = {host_req_i.addr[15:2], 2'h0};
  wire logic [15:0] ent_base = `LUTAC_ENTRY_BASE_OFS;
  wire logic hit_kh = hits_word(word_addr, `LUTAC_KEY_HIGH_OFS);
  wire logic hit_kl = hits_word(word_addr, `LUTAC_KEY_LOW_OFS);
  wire logic hit_alu = hits_word(word_addr, `LUTAC_ALU_CTRL_OFS);
  wire logic hit_sm = hits_word(word_addr, `LUTAC_SM_CTRL_OFS);
  // Entry words sit at four consecutive word addresses
  wire logic hit_ent = word_addr[15:4] == ent_base[15:4];
  wire logic [1:0] ent_sel = word_addr[3:2];
  wire logic wr_kh = host_req_i.wr && hit_kh;
  wire logic wr_kl = host_req_i.wr && hit_kl;
  wire logic wr_alu = host_req_i.wr && hit_alu;
  wire logic wr_sm = host_req_i.wr && hit_sm;
  // Go bits live in the last byte lane of each control word
  wire logic go_lane = lane == 2'h3;
  wire logic go_bit_wr = host_req_i.wdata[`LUTAC_GO_BIT];

  // Starting is only taken when nothing is pending or running, so a
  // second go cannot overtake the access already in progress.
  wire logic engine_free = state == LUTAC_ST_IDLE && !alu_go && !sm_go;
  wire logic alu_start = wr_alu && go_lane && go_bit_wr && engine_free; // R6
  wire logic sm_start = wr_sm && go_lane && go_bit_wr && engine_free; // R13

  // The entry-ready flag clears on a read of the very last data byte
  wire logic last_byte_rd = host_req_i.rd &&
                            host_req_i.addr == `LUTAC_ENTRY_LAST_BYTE; // R7 R18

  // Sequencer decisions
  wire logic issue_alu = state == LUTAC_ST_IDLE && alu_go;
  wire logic issue_sm = state == LUTAC_ST_IDLE && !alu_go && sm_go;
  wire logic issue_nop = issue_alu && built_cmd.op == LUTAC_OP_NOP; // R10
  wire logic issue_srch = issue_alu && built_cmd.op == LUTAC_OP_SEARCH;
  // A search is announced to the engine by a request of its own
  wire logic issue_any = (issue_alu && !issue_nop) || issue_sm;
  wire logic access_done = state == LUTAC_ST_ACCESS && tbl_ack_i;
  wire logic in_search = state == LUTAC_ST_SEARCH;
  wire logic srch_hit = in_search && srch_entry_i;
  wire logic srch_fin = in_search && srch_end_i;
  wire logic load_read = access_done && tbl_cmd_o.op == LUTAC_OP_READ;
  // Only the second entry word takes a multicast read
  wire logic load_mcast = tbl_cmd_o.tsel == LUTAC_TBL_MCAST;
  wire logic ask_next = in_search && entry_ready && last_byte_rd; // R20
  wire logic alu_is_tbl = tbl_cmd_o.tsel == LUTAC_TBL_ALU;
  // Completion of each table's access
  wire logic alu_done = issue_nop || srch_fin || (access_done && alu_is_tbl);
  wire logic sm_done = access_done && !alu_is_tbl;

  // Readback
  wire logic [31:0] alu_view = {2'h0, valid_count, 8'h00, alu_go,
                                entry_ready, entry_ready | search_ended,
                                alu_ctrl[4:0]}; // R5 R6 R7 R8
  wire logic [31:0] sm_view = {sm_ctrl[31:8], sm_go, sm_ctrl[6:0]}; // R13
  wire logic [31:0] rd_word =
    hit_kh ? key_high :
    hit_kl ? key_low :
    hit_alu ? alu_view :
    hit_sm ? sm_view :
    hit_ent ? entry[ent_sel] : 32'h0000_0000;
  wire logic [7:0] rd_byte = pick_byte(rd_word, lane);

  lutac_cmd_build u_cmd_build (
    .key_high_i(key_high),
    .key_low_i(key_low),
    .alu_ctrl_i(alu_ctrl),
    .sm_ctrl_i(sm_ctrl),
    .pick_sm_i(!alu_go),
    .cmd_o(built_cmd)
  );

  lutac_flag u_entry_ready (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(srch_hit),
    .clr_i(last_byte_rd || issue_srch),
    .q_o(entry_ready)
  ); // R7

  // Stays set after the end so bit 5 still reads one once idle
  lutac_flag u_search_ended (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .set_i(srch_fin),
    .clr_i(issue_srch),
    .q_o(search_ended)
  ); // R8

  // Sequencer
  // There is no timeout: a silent engine leaves the go bit set, which
  // software sees as a table that never finishes.
  always_comb begin
    next_state = state;
    unique case (state)
      LUTAC_ST_IDLE: begin
        if (issue_srch) begin
          next_state = LUTAC_ST_SEARCH;
        end else if (issue_any) begin
          next_state = LUTAC_ST_ACCESS;
        end
      end
      LUTAC_ST_ACCESS: begin
        if (tbl_ack_i) begin
          next_state = LUTAC_ST_IDLE;
        end
      end
      LUTAC_ST_SEARCH: begin
        if (srch_end_i) begin
          next_state = LUTAC_ST_IDLE;
        end
      end
      default: begin
        next_state = LUTAC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= LUTAC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Key and control registers; reserved read-write bits are kept so
  // software reads back what it wrote
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_high <= `LUTAC_KEY_HIGH_RST;
    end else if (wr_kh) begin
      key_high <= merge_byte(key_high, lane, host_req_i.wdata,
                             `LUTAC_KEY_HIGH_WMASK); // R1 R2
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      key_low <= `LUTAC_KEY_LOW_RST;
    end else if (wr_kl) begin
      key_low <= merge_byte(key_low, lane, host_req_i.wdata,
                            `LUTAC_KEY_LOW_WMASK); // R3
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alu_ctrl <= `LUTAC_ALU_CTRL_RST;
    end else if (wr_alu) begin
      alu_ctrl <= merge_byte(alu_ctrl, lane, host_req_i.wdata,
                             `LUTAC_ALU_CTRL_WMASK); // R9 R10
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sm_ctrl <= `LUTAC_SM_CTRL_RST;
    end else if (wr_sm) begin
      sm_ctrl <= merge_byte(sm_ctrl, lane, host_req_i.wdata,
                            `LUTAC_SM_CTRL_WMASK); // R11 R14 R15
    end
  end

  // Go bits: set by the host, cleared by the sequencer on completion
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alu_go <= 1'b0;
    end else if (alu_start) begin
      alu_go <= 1'b1;
    end else if (alu_done) begin
      alu_go <= 1'b0; // R6
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sm_go <= 1'b0;
    end else if (sm_start) begin
      sm_go <= 1'b1;
    end else if (sm_done) begin
      sm_go <= 1'b0; // R13
    end
  end

  // Count is only refreshed at the end of a search; it keeps the last
  // result across other accesses.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_count <= `LUTAC_COUNT_RST;
    end else if (srch_fin) begin
      valid_count <= srch_count_i; // R5
    end
  end

  // Entry data words, one per generate step
  for (genvar i = 0; i < 4; i++) begin : g_entry
    wire logic host_wr = host_req_i.wr && hit_ent && ent_sel == 2'(i);
    wire logic word_used = !load_mcast || i == 1; // R16
    wire logic hw_load = (load_read && word_used) || srch_hit; // R17
    wire logic [31:0] host_word =
      merge_byte(entry[i], lane, host_req_i.wdata, 32'hffff_ffff);
    // A table load in the same cycle as a host write wins
    always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        entry[i] <= `LUTAC_ENTRY_RST;
      end else if (hw_load) begin
        entry[i] <= tbl_rdata_i[i];
      end else if (host_wr) begin
        entry[i] <= host_word;
      end
    end
  end

  // Table request, registered so the outputs come from flip-flops
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tbl_req_o <= 1'b0;
    end else begin
      tbl_req_o <= issue_any;
    end
  end

  // Command and data snapshot hold until the next request
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tbl_cmd_o <= '0;
      tbl_wdata_o <= '0;
    end else if (issue_any) begin
      tbl_cmd_o <= built_cmd; // R4 R12 R17
      tbl_wdata_o <= entry;
    end
  end

  // One-cycle request for the next entry once the host has drained
  // the last data byte
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srch_next_o <= 1'b0;
    end else begin
      srch_next_o <= ask_next; // R20
    end
  end

  // Host answer: one cycle after the read strobe
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_rsp_o <= '0;
    end else begin
      host_rsp_o.rvalid <= host_req_i.rd;
      host_rsp_o.rdata <= host_req_i.rd ? rd_byte : 8'h00;
    end
  end

endmodule // lutac_main
`default_nettype wire

// File: tb/lutac_properties.sv
// Port checks for the lookup table access control block.
// Assumes it is bound to lutac_main; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "lutac_defines.svh"
module lutac_properties
  import lutac_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Host port
  input wire lutac_host_req_t host_req_i,
  input wire lutac_host_rsp_t host_rsp_o,
  // Table side
  input wire logic tbl_req_o,
  input wire lutac_cmd_t tbl_cmd_o,
  input wire logic srch_next_o
);
  wire logic last_rd;
  wire logic is_alu;
  assign last_rd = host_req_i.rd && host_req_i.addr == `LUTAC_ENTRY_LAST_BYTE;
  assign is_alu = tbl_cmd_o.tsel == LUTAC_TBL_ALU;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  property p_last_read_answer;
    last_rd |=> host_rsp_o.rvalid;
  endproperty
  a_last_read_answer: assert property (p_last_read_answer)
    else $error("no answer to entry byte read");
  property p_no_stray_answer;
    !host_req_i.rd |=> !host_rsp_o.rvalid && host_rsp_o.rdata == 8'h00;
  endproperty
  a_no_stray_answer: assert property (p_no_stray_answer)
    else $error("read answer without a read");
  property p_next_cause;
    srch_next_o |-> $past(last_rd);
  endproperty
  a_next_cause: assert property (p_next_cause)
    else $error("next entry asked without last byte read");
  property p_req_pulse;
    tbl_req_o |=> !tbl_req_o;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("table request longer than one cycle");
  property p_req_ops;
    tbl_req_o |-> tbl_cmd_o.op inside {LUTAC_OP_WRITE, LUTAC_OP_READ,
                                       LUTAC_OP_SEARCH};
  endproperty
  a_req_ops: assert property (p_req_ops)
    else $error("table request for nop");
  property p_search_lookup;
    tbl_req_o && tbl_cmd_o.op == LUTAC_OP_SEARCH |-> is_alu;
  endproperty
  a_search_lookup: assert property (p_search_lookup)
    else $error("search request outside the lookup table");
  property p_static_idx;
    tbl_req_o && tbl_cmd_o.tsel == LUTAC_TBL_STATIC
      |-> tbl_cmd_o.index[11:4] == 8'h00;
  endproperty
  a_static_idx: assert property (p_static_idx)
    else $error("static index too wide");
  property p_mcast_idx;
    tbl_req_o && tbl_cmd_o.tsel == LUTAC_TBL_MCAST
      |-> tbl_cmd_o.index[11:6] == 6'h00;
  endproperty
  a_mcast_idx: assert property (p_mcast_idx)
    else $error("multicast index too wide");
  property p_hash_idx;
    tbl_req_o && is_alu && !tbl_cmd_o.direct |-> tbl_cmd_o.index == 12'h000;
  endproperty
  a_hash_idx: assert property (p_hash_idx)
    else $error("hashed access carries an index");
  property p_cmd_hold;
    !tbl_req_o |-> $stable(tbl_cmd_o);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command moved without a request");
  c_lookup: cover property (tbl_req_o && is_alu);
  c_mcast: cover property (tbl_req_o && tbl_cmd_o.tsel == LUTAC_TBL_MCAST);
  c_next: cover property (srch_next_o);
  c_search: cover property (tbl_req_o && tbl_cmd_o.op == LUTAC_OP_SEARCH);
endmodule // lutac_properties
`default_nettype wire

// File: tb/lutac_test.sv
// Self-checking bench for the lookup table access control block.
// Assumes the bench plays both host and table engine at the ports.
`timescale 1ns/1ps
`default_nettype none
module lutac_test;
  import lutac_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  lutac_host_req_t req = '0;
  lutac_host_rsp_t rsp;
  logic tbl_req, s_next, nxt;
  logic ack = 1'b0, s_entry = 1'b0, s_end = 1'b0;
  lutac_cmd_t cmd;
  lutac_entry_t wd, ent, rdat = '0;
  logic [13:0] cnt = 14'h0000;
  int failures = 0;
  int checked = 0;
  always #25 mclk_i = ~mclk_i;
  lutac_main dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .host_req_i(req),
    .host_rsp_o(rsp), .tbl_req_o(tbl_req), .tbl_cmd_o(cmd),
    .tbl_wdata_o(wd), .tbl_ack_i(ack), .tbl_rdata_i(rdat),
    .srch_entry_i(s_entry), .srch_end_i(s_end), .srch_count_i(cnt),
    .srch_next_o(s_next));
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, exp, input string w);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge mclk_i);
    #1;
    req.wr = 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge mclk_i);
    #1;
    req.rd = 1'b0;
    cmp(64'(rsp.rvalid), 64'h1, "rvalid");
    d = rsp.rdata;
    nxt = s_next;
  endtask
  task automatic chk8(input logic [15:0] a, input logic [7:0] e, string w);
    logic [7:0] b;
    rd8(a, b);
    cmp(64'(b), 64'(e), w);
  endtask
  task automatic wr32(input logic [15:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      wr8(a + 16'(i), d[31 - 8 * i -: 8]);
  endtask
  task automatic chk32(input logic [15:0] a, input logic [31:0] e, string w);
    logic [31:0] g;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rd8(a + 16'(i), b);
      g[31 - 8 * i -: 8] = b;
    end
    cmp(64'(g), 64'(e), w);
  endtask
  // Data is only shown with the strobe; afterwards it is scrambled
  task automatic pulse(input int k, input lutac_entry_t v);
    @(posedge mclk_i);
    #1;
    rdat = v;
    ack = k == 0;
    s_entry = k == 1;
    s_end = k == 2;
    @(posedge mclk_i);
    #1;
    {ack, s_entry, s_end} = 3'h0;
    rdat = ~v;
  endtask
  task automatic run_op(input logic [15:0] a, input logic [7:0] ctl,
      input logic [16:0] e, input logic mc);
    lutac_entry_t v;
    for (int i = 0; i < 4; i++)
      v[i] = {ctl, 8'(i), 16'hbeef};
    wr8(a, ctl);
    for (int i = 0; i < 20 && tbl_req !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (tbl_req !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: no table request", $time);
      tally_and_finish();
    end
    cmp(64'({cmd.tsel, cmd.op, cmd.direct, cmd.index}), 64'(e), "cmd");
    if (e[16:15] == LUTAC_TBL_ALU)
      cmp(64'({cmd.filter_group_id, cmd.mac}),
        {9'h0, 7'h35, 48'h0123_4567_89ab}, "key");
    cmp({wd[3], wd[1]}, {ent[3], ent[1]}, "wdata");
    chk8(a, ctl, "go held");
    pulse(0, v);
    chk8(a, ctl & 8'h7f, "go done");
    if (e[14:13] == LUTAC_OP_READ) begin
      if (mc) begin
        ent[1] = v[1];
      end else begin
        ent = v;
      end
      chk32(16'h0424, ent[1], "word 1");
      chk32(16'h0420, ent[0], "word 0");
    end
  endtask
  initial begin
    ent = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    repeat (8) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    for (int i = 0; i < 5; i++)
      chk32(i < 4 ? 16'h0410 + 16'(4 * i) : 16'h0500, 32'h0, "reset");
    wr32(16'h0410, 32'hffff_ffff);
    chk32(16'h0410, 32'h807f_ffff, "key mask");
    wr32(16'h0500, 32'h1234_5678);
    chk32(16'h0500, 32'h0, "unmapped");
    $display("test registers done");
    wr32(16'h0410, 32'h0035_0123);
    wr32(16'h0414, 32'h4567_89ab);
    wr32(16'h041c, 32'h003a_0000);
    for (int i = 0; i < 4; i++)
      wr32(16'h0420 + 16'(4 * i), ent[i]);
    run_op(16'h041b, 8'h81, {LUTAC_TBL_ALU, LUTAC_OP_WRITE, 13'h0}, 0);
    run_op(16'h041b, 8'h86, {LUTAC_TBL_ALU, LUTAC_OP_READ, 13'h19ab}, 0);
    run_op(16'h041f, 8'h80, {LUTAC_TBL_STATIC, LUTAC_OP_WRITE, 13'h100a},
      0);
    run_op(16'h041f, 8'h83, {LUTAC_TBL_MCAST, LUTAC_OP_READ, 13'h103a},
      1);
    wr8(16'h041b, 8'h80);
    @(posedge mclk_i);
    #1;
    cmp(64'(tbl_req), 64'h0, "nop request");
    chk8(16'h041b, 8'h00, "nop done");
    $display("test table access done");
    wr8(16'h041b, 8'h83);
    chk8(16'h041b, 8'h83, "search busy");
    pulse(1, {32'h0a0b_0c5d, 96'h0});
    chk8(16'h041b, 8'he3, "entry ready");
    chk8(16'h042f, 8'h5d, "last byte");
    cmp(64'(nxt), 64'h1, "next entry");
    chk8(16'h041b, 8'h83, "ready cleared");
    cnt = 14'h0123;
    pulse(2, '0);
    chk32(16'h0418, 32'h0123_0023, "search end");
    $display("test search done");
    tally_and_finish();
  end
endmodule // lutac_test
bind lutac_main lutac_properties u_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .host_req_i(host_req_i), .host_rsp_o(host_rsp_o), .tbl_req_o(tbl_req_o),
  .tbl_cmd_o(tbl_cmd_o), .srch_next_o(srch_next_o));
`default_nettype wire
